// >>> common/sfw_map.svh
// Opcodes, bit counts and timing constants of the flash command block.
// Assumes a 50 MHz block clock; included by bare name.
`ifndef SFW_MAP_SVH
`define SFW_MAP_SVH
`define SFW_OP_WRAP  8'h77
`define SFW_OP_WORD  8'he7
`define SFW_OP_DPT   8'h5a
`define SFW_OP_PROG  8'h02
`define SFW_OP_CRST  8'hff
`define SFW_OP_NONE  8'h00
`define SFW_CONT_KEY 2'h2
`define SFW_WRAP_RST 3'h1
`define SFW_BYTE_N   5'h07
`define SFW_ADR_Q    5'h05
`define SFW_ADR_S    5'h17
`define SFW_MODE_N   5'h01
`define SFW_DUM_Q    5'h01
`define SFW_DUM_S    5'h07
`define SFW_CRST_N   5'h01
`define SFW_OUT_Q    3'h1
`define SFW_OUT_S    3'h7
`define SFW_OE_Q     4'hf
`define SFW_OE_S     4'h2
`define SFW_SEC_MIN  8'h08
`define SFW_ERASED   8'hff
`define SFW_DPT_SIG  32'h50444653
`define SFW_CLK_NS   20
`define SFW_PROG_NS  400000
`endif

// >>> common/sfw_pkg.sv
// Types shared by the flash command block and its memory array model.
// Assumes nothing beyond a SystemVerilog compiler.
package sfw_pkg;
   typedef enum logic [6:0] {
      FR_OPC  = 7'h01,
      FR_ADR  = 7'h02,
      FR_MODE = 7'h04,
      FR_DUM  = 7'h08,
      FR_DIN  = 7'h10,
      FR_DOUT = 7'h20,
      FR_SKIP = 7'h40
   } sfw_frame_t;
   typedef enum logic [2:0] {
      PG_IDLE = 3'h1,
      PG_WALK = 3'h2,
      PG_WAIT = 3'h4
   } sfw_pg_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [7:0]  data;
   } sfw_word_t;
endpackage

// >>> hdl/sfw_core.sv
// Serial flash command handling: wrap setup, quad word read, parameter
// read and page program. Assumes SPI mode 0 pins sampled by clk_i, SCK
// well below clk_i/4, and a memory array beside it on clk_i.
//
// Notes on behaviour
// R1 - Opcode 77h, 24 dummy bits, 8 wrap bits; last byte latched as setting.
// R2 - Wrap disable bit 1 turns wrapping off and length is ignored.
// R3 - Length field 00/01/10/11 selects 8/16/32/64 byte sections.
// R4 - Wrap disable bit is 1 after power-on reset.
// R5 - Wrap setting persists for all later word reads until rewritten.
// R6 - Wrapped read starts at given address, loops inside its section.
// R7 - Word read E7h has even address and two dummy clocks before data.
// R8 - Without wrap the read address steps up by one per byte.
// R9 - Word read accepted only while the quad permit bit is set.
// R10 - Mode bits 10 let the next frame skip the opcode.
// R11 - A continuous-mode reset frame clears the mode bits.
// R12 - Opcode 5Ah returns the parameter tables.
// R13 - Programming starts only with the write permit latch set.
// R14 - Program is 02h, three address bytes, 1 to 256 data bytes.
// R15 - Data past page end wraps to start of the same page.
// R16 - Beyond 256 bytes only the last 256 are kept.
// R17 - Programming starts at chip select rise; unsent bytes stay erased.
// R18 - Short address, no full byte, or a bit count not a multiple of eight aborts the program.
// R19 - Protected target: nothing programmed, back to idle.
// R20 - Aborts and protection clear the write permit latch.
// R21 - Busy while programming; latch cleared before the cycle ends.
// R22 - Host should poll busy rather than wait the worst-case time.
// R23 - Quad permit is status bit 9; quad commands need it.
// R24 - Wrap sections are aligned to their own length.
`include "sfw_map.svh"

module sfw_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_reg [D];
   logic [AW:0]  wp_reg;
   logic [AW:0]  rp_reg;

   // D must be a power of two for the wrap-bit full test
   assign in_ready_o  = !((wp_reg[AW] != rp_reg[AW]) &&
                          (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
   assign out_valid_o = (wp_reg != rp_reg);
   assign out_data_o  = mem_reg[rp_reg[AW-1:0]];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (in_valid_i && in_ready_o) wp_reg <= wp_reg + 1'b1;
         if (out_valid_o && out_ready_i) rp_reg <= rp_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (in_valid_i && in_ready_o) mem_reg[wp_reg[AW-1:0]] <= in_data_i;
   end
endmodule

module sfw_core #(
   parameter int unsigned PROG_CYC =
      (`SFW_PROG_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS,
   parameter int          FIFO_D   = 4
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        sck_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   output logic [3:0]       io_o,
   output logic [3:0]       io_oe_o,
   input  wire logic        quad_permit_i,
   input  wire logic        write_enable_i,
   input  wire logic        protect_i,
   output logic [23:0]      mem_addr_o,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             prog_valid_o,
   output sfw_pkg::sfw_word_t prog_word_o,
   input  wire logic        prog_ready_i,
   output logic             busy_o,
   output logic             write_permit_o,
   output logic [2:0]       wrap_setting_o,
   output logic             cont_mode_o
);
   logic [2:0]  sck_q;
   logic [2:0]  cs_q;
   logic [3:0]  io_q1;
   logic [3:0]  io_s;
   logic        sck_rise, sck_fall, cs_lo, cs_rise;
   sfw_pkg::sfw_frame_t st_reg;
   sfw_pkg::sfw_pg_t    pg_reg;
   logic [4:0]  cnt_reg, last;
   logic [7:0]  sh_reg, cmd_reg, sh_in;
   logic [23:0] addr_reg, rd_addr_reg;
   logic [2:0]  wrap_reg, wrap_val, ocnt_reg;
   logic        cont_reg, permit_reg, quad, fin, acc, byte_done, crst;
   logic        mode_key, rd_adv, got_reg, bad, prog_abort, pg_start;
   logic [7:0]  rest_reg, src, ptr_reg, idx_reg;
   logic [7:0]  buf_mem [256];
   logic [255:0] mask_reg;
   logic [15:0] page_reg;
   logic [31:0] pg_cnt_reg;
   logic        f_valid, f_ready;
   sfw_pkg::sfw_word_t f_word;

   // Next read address; wrap stays inside an aligned section of the page
   function automatic logic [23:0] next_addr(input logic [23:0] a,
                                             input logic [2:0]  w);
      logic [7:0] m;
      m = (`SFW_SEC_MIN << w[2:1]) - 8'h01;               // [R3] [R24]
      if (w[0]) next_addr = a + 24'h000001;                // [R2] [R8]
      else next_addr = {a[23:8], (a[7:0] & ~m) |
                        ((a[7:0] + 8'h01) & m)};           // [R6]
   endfunction

   function automatic logic [7:0] dpt_byte(input logic [23:0] a);
      logic [31:0] sig;
      sig = `SFW_DPT_SIG;
      if (a[23:2] == 22'h000000) dpt_byte = sig[a[1:0]*8 +: 8];
      else dpt_byte = `SFW_ERASED;
   endfunction

   function automatic logic [3:0] out_bits(input logic [7:0] b,
                                           input logic       q);
      out_bits = q ? b[7:4] : {2'h0, b[7], 1'b0};
   endfunction

   function automatic logic [7:0] out_shift(input logic [7:0] b,
                                            input logic       q);
      out_shift = q ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
   endfunction

   // Pin synchronisers and edge finders
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_q <= 3'h0;
         cs_q  <= 3'h7;
         io_q1 <= 4'h0;
         io_s  <= 4'h0;
      end else begin
         sck_q <= {sck_q[1:0], sck_i};
         cs_q  <= {cs_q[1:0], cs_n_i};
         io_q1 <= io_i;
         io_s  <= io_q1;
      end
   end

   assign sck_rise = sck_q[1] && !sck_q[2];
   assign sck_fall = !sck_q[1] && sck_q[2];
   assign cs_lo    = !cs_q[1];
   assign cs_rise  = cs_q[1] && !cs_q[2];

   assign quad     = (cmd_reg == `SFW_OP_WORD);
   assign sh_in    = {sh_reg[6:0], io_s[0]};
   assign wrap_val = sh_in[6:4];
   // Only mode bits 5:4 decide; the other mode bits are ignored
   assign mode_key = (sh_reg[1:0] == `SFW_CONT_KEY);          // [R10]
   assign acc = (sh_in == `SFW_OP_WRAP) ||
                (!busy_o && (sh_in == `SFW_OP_DPT ||
                 sh_in == `SFW_OP_PROG ||
                 (sh_in == `SFW_OP_WORD && quad_permit_i)));  // [R9] [R23]

   always_comb begin
      case (st_reg)
         sfw_pkg::FR_OPC,
         sfw_pkg::FR_DIN:  last = `SFW_BYTE_N;
         sfw_pkg::FR_ADR:  last = quad ? `SFW_ADR_Q : `SFW_ADR_S;
         sfw_pkg::FR_MODE: last = `SFW_MODE_N;
         sfw_pkg::FR_DUM:  last = quad ? `SFW_DUM_Q : `SFW_DUM_S; // [R7]
         default:          last = 5'h00;
      endcase
   end

   assign fin = sck_rise && cs_lo && (cnt_reg == last) &&
                st_reg != sfw_pkg::FR_DOUT && st_reg != sfw_pkg::FR_SKIP;
   assign byte_done = fin && st_reg == sfw_pkg::FR_DIN;
   assign crst = sck_rise && cs_lo &&
      ((fin && st_reg == sfw_pkg::FR_OPC && sh_in == `SFW_OP_CRST) ||
       (st_reg == sfw_pkg::FR_ADR && quad && cnt_reg == `SFW_CRST_N &&
        {addr_reg[3:0], io_s} == `SFW_OP_CRST));

   // Frame sequencer; with quad permit set, continuous mode opens a frame at the address phase
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg   <= sfw_pkg::FR_OPC;
         cnt_reg  <= 5'h00;
         sh_reg   <= 8'h00;
         cmd_reg  <= `SFW_OP_NONE;
         addr_reg <= 24'h000000;
      end else if (!cs_lo) begin
         cnt_reg <= 5'h00;
         if (cont_reg && quad_permit_i) begin                 // [R10]
            st_reg  <= sfw_pkg::FR_ADR;
            cmd_reg <= `SFW_OP_WORD;
         end else begin
            st_reg  <= sfw_pkg::FR_OPC;
            cmd_reg <= `SFW_OP_NONE;
         end
      end else if (sck_rise) begin
         sh_reg  <= quad ? {sh_reg[3:0], io_s} : sh_in;
         cnt_reg <= fin ? 5'h00 : cnt_reg + 5'h01;
         if (st_reg == sfw_pkg::FR_ADR)
            addr_reg <= quad ? {addr_reg[19:0], io_s} :
                               {addr_reg[22:0], io_s[0]};
         if (crst) st_reg <= sfw_pkg::FR_SKIP;                 // [R11]
         else if (fin) begin
            case (st_reg)
               sfw_pkg::FR_OPC: begin
                  cmd_reg <= acc ? sh_in : `SFW_OP_NONE;
                  st_reg  <= acc ? sfw_pkg::FR_ADR : sfw_pkg::FR_SKIP;
               end
               sfw_pkg::FR_ADR: begin
                  if (quad) st_reg <= sfw_pkg::FR_MODE;
                  else if (cmd_reg == `SFW_OP_DPT)
                     st_reg <= sfw_pkg::FR_DUM;
                  else st_reg <= sfw_pkg::FR_DIN;              // [R1] [R14]
               end
               sfw_pkg::FR_MODE: st_reg <= sfw_pkg::FR_DUM;
               sfw_pkg::FR_DUM:  st_reg <= sfw_pkg::FR_DOUT;   // [R7]
               sfw_pkg::FR_DIN: begin
                  if (cmd_reg == `SFW_OP_WRAP) st_reg <= sfw_pkg::FR_SKIP;
               end
               default: st_reg <= st_reg;
            endcase
         end
      end
   end

   // Wrap setting and continuous-mode bits
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) wrap_reg <= `SFW_WRAP_RST;                // [R4]
      else if (byte_done && cmd_reg == `SFW_OP_WRAP)
         wrap_reg <= wrap_val;                                 // [R1] [R5]
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) cont_reg <= 1'b0;
      else if (fin && st_reg == sfw_pkg::FR_MODE)
         cont_reg <= mode_key;                                 // [R10]
      else if (crst) cont_reg <= 1'b0;                         // [R11]
   end

   // Read data path, shifted out on falling SCK
   assign src = (cmd_reg == `SFW_OP_DPT) ? dpt_byte(rd_addr_reg) :
                                            mem_rdata_i;       // [R12]
   assign rd_adv = sck_fall && cs_lo && st_reg == sfw_pkg::FR_DOUT &&
                   ocnt_reg == 3'h0;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         io_o        <= 4'h0;
         io_oe_o     <= 4'h0;
         rest_reg    <= 8'h00;
         ocnt_reg    <= 3'h0;
         rd_addr_reg <= 24'h000000;
      end else if (!cs_lo) begin
         io_oe_o  <= 4'h0;
         ocnt_reg <= 3'h0;
      end else begin
         if (fin && st_reg == sfw_pkg::FR_DUM) rd_addr_reg <= addr_reg;
         if (sck_fall && st_reg == sfw_pkg::FR_DOUT) begin
            io_oe_o  <= quad ? `SFW_OE_Q : `SFW_OE_S;
            ocnt_reg <= (ocnt_reg == (quad ? `SFW_OUT_Q : `SFW_OUT_S)) ?
                        3'h0 : ocnt_reg + 3'h1;
            if (ocnt_reg == 3'h0) begin
               io_o        <= out_bits(src, quad);
               rest_reg    <= out_shift(src, quad);
               rd_addr_reg <= next_addr(rd_addr_reg,
                  quad ? wrap_reg : `SFW_WRAP_RST);            // [R5] [R8]
            end else begin
               io_o     <= out_bits(rest_reg, quad);
               rest_reg <= out_shift(rest_reg, quad);
            end
         end
      end
   end

   // Page buffer: index wraps inside the page, so the last 256 bytes win
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ptr_reg  <= 8'h00;
         got_reg  <= 1'b0;
         mask_reg <= '0;
      end else begin
         if (fin && st_reg == sfw_pkg::FR_OPC && acc &&
             sh_in == `SFW_OP_PROG) begin
            mask_reg <= '0;
            got_reg  <= 1'b0;
         end
         if (fin && st_reg == sfw_pkg::FR_ADR && cmd_reg == `SFW_OP_PROG)
            ptr_reg <= {addr_reg[6:0], io_s[0]};
         if (byte_done && cmd_reg == `SFW_OP_PROG) begin
            mask_reg[ptr_reg] <= 1'b1;                         // [R14]
            ptr_reg <= ptr_reg + 8'h01;                        // [R15] [R16]
            got_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (byte_done && cmd_reg == `SFW_OP_PROG) buf_mem[ptr_reg] <= sh_in;
   end

   // End-of-frame decision for a program frame
   assign bad = st_reg != sfw_pkg::FR_DIN || cnt_reg != 5'h00 ||
                !got_reg;                                      // [R18]
   assign prog_abort = cs_rise && cmd_reg == `SFW_OP_PROG &&
                       (bad || protect_i);                     // [R19]
   assign pg_start = cs_rise && cmd_reg == `SFW_OP_PROG && !bad &&
                     !protect_i && permit_reg &&
                     pg_reg == sfw_pkg::PG_IDLE;               // [R13] [R17]

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) permit_reg <= 1'b0;
      else if (write_enable_i) permit_reg <= 1'b1;
      else if (prog_abort || pg_start) permit_reg <= 1'b0;     // [R20] [R21]
   end

   // Self-timed program: unsent locations are skipped and stay erased
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pg_reg     <= sfw_pkg::PG_IDLE;
         idx_reg    <= 8'h00;
         page_reg   <= 16'h0000;
         pg_cnt_reg <= 32'h00000000;
      end else begin
         case (pg_reg)
            sfw_pkg::PG_IDLE: begin
               if (pg_start) begin
                  pg_reg     <= sfw_pkg::PG_WALK;              // [R17]
                  idx_reg    <= 8'h00;
                  page_reg   <= addr_reg[23:8];
                  pg_cnt_reg <= 32'h00000000;
               end
            end
            sfw_pkg::PG_WALK: begin
               if (!mask_reg[idx_reg] || f_ready) begin
                  idx_reg <= idx_reg + 8'h01;
                  if (idx_reg == 8'hff) pg_reg <= sfw_pkg::PG_WAIT;
               end
            end
            sfw_pkg::PG_WAIT: begin
               if (!prog_valid_o) begin
                  if (pg_cnt_reg == PROG_CYC - 1) pg_reg <= sfw_pkg::PG_IDLE;
                  else pg_cnt_reg <= pg_cnt_reg + 32'h00000001;
               end
            end
            default: pg_reg <= sfw_pkg::PG_IDLE;
         endcase
      end
   end

   assign f_valid     = pg_reg == sfw_pkg::PG_WALK && mask_reg[idx_reg];
   assign f_word.addr = {page_reg, idx_reg};
   assign f_word.data = buf_mem[idx_reg];

   sfw_fifo #(
      .W ($bits(sfw_pkg::sfw_word_t)),
      .D (FIFO_D)
   ) u_fifo (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (f_valid),
      .in_ready_o  (f_ready),
      .in_data_i   (f_word),
      .out_valid_o (prog_valid_o),
      .out_ready_i (prog_ready_i),
      .out_data_o  (prog_word_o)
   );

   assign busy_o         = pg_reg != sfw_pkg::PG_IDLE;         // [R21]
   assign write_permit_o = permit_reg;
   assign wrap_setting_o = wrap_reg;
   assign cont_mode_o    = cont_reg;
   assign mem_addr_o     = rd_addr_reg;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_word_open;
      fin && st_reg == sfw_pkg::FR_OPC && sh_in == `SFW_OP_WORD;
   endsequence
   sequence s_prog_end;
      cs_rise && cmd_reg == `SFW_OP_PROG;
   endsequence

   chk_quad_gate: assert property ( // [R9]
      s_word_open ##0 !quad_permit_i |=> st_reg == sfw_pkg::FR_SKIP)
      else $error("word read w/o permit");
   chk_wrap_load: assert property ( // [R1]
      byte_done && cmd_reg == `SFW_OP_WRAP |=> wrap_reg == $past(wrap_val))
      else $error("wrap not latched");
   chk_wrap_keep: assert property ( // [R5]
      !(byte_done && cmd_reg == `SFW_OP_WRAP) |=> $stable(wrap_reg))
      else $error("wrap setting drifted");
   chk_cont_set: assert property ( // [R10]
      fin && st_reg == sfw_pkg::FR_MODE |=> cont_reg == $past(mode_key))
      else $error("mode bits lost");
   chk_cont_clear: assert property ( // [R11]
      crst |=> !cont_reg)
      else $error("continuous mode kept");
   chk_flat_step: assert property ( // [R8]
      rd_adv && quad && wrap_reg[0]
      |=> rd_addr_reg == $past(rd_addr_reg) + 24'h000001)
      else $error("read address not stepped");
   chk_wrap_section: assert property ( // [R6]
      rd_adv && quad && !wrap_reg[0]
      |=> rd_addr_reg[23:6] == $past(rd_addr_reg[23:6]))
      else $error("wrap left section");
   chk_page_wrap: assert property ( // [R15]
      byte_done && cmd_reg == `SFW_OP_PROG
      |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("bad index");
   chk_no_permit: assert property ( // [R13]
      s_prog_end ##0 !permit_reg |=> pg_reg == sfw_pkg::PG_IDLE)
      else $error("program w/o permit");
   chk_abort_idle: assert property ( // [R20]
      prog_abort && !write_enable_i |=> !permit_reg && !busy_o)
      else $error("abort not clean");
   chk_busy_run: assert property ( // [R21]
      pg_start |=> busy_o [*4] ##0 (!permit_reg || $past(write_enable_i)))
      else $error("busy or latch wrong");
endmodule

// >>> testbench/sfw_array_model.sv
// Memory array model beside the flash command block.
// Assumes reads are combinational and one program word is taken per
// valid and ready clock; page 1 holds a pattern, everything else is erased.
module sfw_array_model (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   input  wire logic [23:0]        mem_addr_i,
   output logic [7:0]              mem_rdata_o,
   input  wire logic               prog_valid_i,
   input  wire sfw_pkg::sfw_word_t prog_word_i,
   output logic                    prog_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:4095];
   logic [5:0] stall_reg;
   int         nwr;
   initial begin
      nwr = 0;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = (i[11:8] == 4'h1) ? (i[7:0] ^ 8'h3c) : 8'hff;
      end
   end
   // Slow array: one word every 64 clocks, so the FIFO fills and refuses
   assign prog_ready_o = (stall_reg == 6'h00);
   assign mem_rdata_o  = mem[mem_addr_i[11:0]];
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stall_reg <= 6'h00;
      end else begin
         stall_reg <= stall_reg + 6'h01;
      end
   end
   always @(posedge clk_i) begin
      if (prog_valid_i && prog_ready_o) begin
         mem[prog_word_i.addr[11:0]] <= prog_word_i.data;
         nwr <= nwr + 1;
      end
   end
endmodule

// >>> testbench/sfw_core_bench.sv
// Self-checking bench for the flash command block, host side by tasks.
// Assumes the array model above and a 180 ns serial clock inside frames.
module sfw_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk_i = 0, arst_n_i = 0, sck = 0, cs_n = 1;
   logic               qp = 0, we = 0, prot = 0, pv, pr, busy, wp, cm;
   logic [3:0]         io_i = 4'h0, io_o, io_oe, q;
   logic [23:0]        maddr;
   logic [7:0]         mrd, b;
   logic [2:0]         ws;
   sfw_pkg::sfw_word_t pw;
   int                 err_total = 0, checks_done = 0, cyc = 0, s, n0;

   sfw_core #(.PROG_CYC(16), .FIFO_D(4)) DUT (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_i),
      .io_o(io_o), .io_oe_o(io_oe), .quad_permit_i(qp),
      .write_enable_i(we), .protect_i(prot), .mem_addr_o(maddr),
      .mem_rdata_i(mrd), .prog_valid_o(pv), .prog_word_o(pw),
      .prog_ready_i(pr), .busy_o(busy), .write_permit_o(wp),
      .wrap_setting_o(ws), .cont_mode_o(cm));
   sfw_array_model m (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .mem_addr_i(maddr), .mem_rdata_o(mrd), .prog_valid_i(pv),
      .prog_word_i(pw), .prog_ready_o(pr));

   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task tally_and_finish;
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One serial clock: data set with the fall, output taken before next
   task clk1(input logic [3:0] d);
      @(posedge clk_i);
      sck <= 1'b0;
      io_i <= d;
      tick(4);
      sck <= 1'b1;
      tick(4);
      #1 q = io_o;
   endtask
   task sbyte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         clk1({3'h0, v[i]});
         b = {b[6:0], q[1]};
      end
   endtask
   task qbyte(input logic [7:0] v);
      clk1(v[7:4]);
      b[7:4] = q;
      clk1(v[3:0]);
      b[3:0] = q;
   endtask
   task cs_lo;
      @(posedge clk_i);
      cs_n <= 1'b0;
      tick(4);
   endtask
   task cs_hi;
      @(posedge clk_i);
      sck <= 1'b0;
      tick(4);
      cs_n <= 1'b1;
      tick(6);
   endtask
   task word_rd(input logic op, input logic [23:0] ad, input logic [7:0] md);
      cs_lo;
      if (op) sbyte(8'he7);
      qbyte(ad[23:16]);
      qbyte(ad[15:8]);
      qbyte(ad[7:0]);
      qbyte(md);
      clk1(4'ha);
      clk1(4'h5);
   endtask
   task wrap_set(input logic [7:0] w);
      cs_lo;
      sbyte(8'h77);
      repeat (3) sbyte(8'h00);
      sbyte(w);
      cs_hi;
   endtask
   task prog(input logic wen, input logic [23:0] ad, input int n,
             input int bits);
      @(posedge clk_i);
      we <= wen;
      @(posedge clk_i);
      we <= 1'b0;
      cs_lo;
      sbyte(8'h02);
      sbyte(ad[23:16]);
      sbyte(ad[15:8]);
      sbyte(ad[7:0]);
      for (int k = 0; k < n; k++) sbyte(8'(k + (k >> 8) * 64));
      repeat (bits) clk1(4'h1);
      cs_hi;
   endtask
   task wait_idle;
      for (int i = 0; i < 20000 && busy !== 1'b0; i++) tick(1);
   endtask

   initial begin
      tick(6);
      arst_n_i <= 1'b1;
      tick(4);
      chk(ws, 3'h1);
      chk({busy, wp}, 2'h0);
      word_rd(1, 24'h000104, 8'h00);
      qbyte(8'h5a);
      chk(io_oe, 4'h0);
      cs_hi;
      qp <= 1'b1;
      word_rd(1, 24'h000104, 8'h00);
      for (int k = 0; k < 3; k++) begin
         qbyte(8'h5a);
         chk(b, m.mem[12'h104 + k]);
      end
      chk(io_oe, 4'hf);
      cs_hi;
      for (int l = 0; l < 4; l++) begin
         s = 8 << l;
         wrap_set({1'b0, 2'(l), 5'h00});
         chk(ws, {2'(l), 1'b0});
         for (int r = 0; r < 2; r++) begin
            word_rd(1, 24'(256 + 3 * s - 2), 8'h00);
            for (int k = 0; k < 4; k++) begin
               qbyte(8'h5a);
               n0 = 256 + 2 * s + (s - 2 + k) % s;
               chk(b, m.mem[n0[11:0]]);
            end
            cs_hi;
         end
      end
      // Disable set with a nonzero length: the length must be ignored
      wrap_set(8'h70);
      chk(ws, 3'h7);
      word_rd(1, 24'h00013e, 8'h00);
      for (int k = 0; k < 4; k++) begin
         qbyte(8'h5a);
         chk(b, m.mem[12'h13e + k]);
      end
      cs_hi;
      word_rd(1, 24'h000110, 8'h20);
      qbyte(8'h5a);
      cs_hi;
      chk(cm, 1'b1);
      word_rd(0, 24'h000120, 8'h00);
      qbyte(8'h5a);
      chk(b, m.mem[12'h120]);
      cs_hi;
      chk(cm, 1'b0);
      word_rd(1, 24'h000110, 8'h20);
      cs_hi;
      cs_lo;
      qbyte(8'hff);
      cs_hi;
      chk(cm, 1'b0);
      word_rd(1, 24'h000110, 8'hea);
      cs_hi;
      chk(cm, 1'b1);
      // Permit off: next frame starts at the opcode, FFh opcode resets
      qp <= 1'b0;
      cs_lo;
      sbyte(8'hff);
      cs_hi;
      chk(cm, 1'b0);
      qp <= 1'b1;
      cs_lo;
      sbyte(8'h5a);
      repeat (4) sbyte(8'h00);
      for (int k = 0; k < 4; k++) begin
         sbyte(8'h00);
         chk(b, 8'(32'h50444653 >> (8 * k)));
      end
      cs_hi;
      n0 = m.nwr;
      prog(0, 24'h0002fe, 3, 0);
      chk({busy, wp}, 2'h0);
      prog(1, 24'h0002fe, 3, 0);
      chk({busy, wp}, 2'h2);
      word_rd(1, 24'h000104, 8'h00);
      qbyte(8'h5a);
      chk(io_oe, 4'h0);
      cs_hi;
      wait_idle;
      chk(busy, 1'b0);
      chk({m.mem[12'h2fe], m.mem[12'h2ff]}, 16'h0001);
      chk(m.mem[12'h200], 8'h02);
      chk(m.mem[12'h201], 8'hff);
      chk(m.nwr - n0, 3);
      prog(1, 24'h000400, 1, 4);
      chk({busy, wp}, 2'h0);
      prog(1, 24'h000400, 0, 0);
      chk({busy, wp}, 2'h0);
      prot <= 1'b1;
      prog(1, 24'h000400, 1, 0);
      chk({busy, wp}, 2'h0);
      prot <= 1'b0;
      chk(m.nwr - n0, 3);
      prog(1, 24'h000300, 258, 0);
      wait_idle;
      chk({m.mem[12'h300], m.mem[12'h301]}, 16'h4041);
      chk(m.mem[12'h302], 8'h02);
      chk(m.nwr - n0, 259);
      tally_and_finish;
   end
endmodule
